/* src/seep_pkg.sv */
/*
 * Shared constants for the serial eeprom pin-protocol slave: timing
 * figures, instruction field widths, opcodes and state encodings.
 * Assumes a single 100 MHz core clock.
 */
package seep_pkg;
   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int CLK_MHZ       = 100;
   localparam int TICK_NS       = 1000;                       // timer grain, 1 us
   localparam int TICK_CYC      = (TICK_NS * CLK_MHZ + 999) / 1000;
   localparam int MIN_DESEL_NS  = 100;                        // min_deselect_time
   localparam int MIN_DESEL_CYC = (MIN_DESEL_NS * CLK_MHZ + 999) / 1000;
   localparam int T_WR8_MS      = 1;
   localparam int T_WR16_MS     = 2;
   localparam int T_ALL_MS      = 15;
   localparam int TICKS_PER_MS  = 1000000 / TICK_NS;
   localparam int TMR_W         = 14;

   // ***************************************************************
   // instruction fields
   // ***************************************************************
   localparam int          OP_W       = 4;
   localparam int          ADDR_W8    = 7;
   localparam int          ADDR_W16   = 6;
   localparam int          DATA_W8    = 8;
   localparam int          DATA_W16   = 16;
   localparam int          WORDS      = 64;
   localparam logic [1:0]  OP_EN      = 2'h3;                 // program_enable_cmd, low bits
   localparam logic [1:0]  OP_DIS     = 2'h0;                 // program_disable_cmd
   localparam logic [1:0]  OP_ERA     = 2'h2;                 // erase_all_cmd
   localparam logic [1:0]  OP_FILL    = 2'h1;                 // fill_all_cmd
   localparam logic [15:0] ERASED     = 16'hFFFF;
   localparam int          ENT_W      = 26;                   // kind, addr, data, wide

   // ***************************************************************
   // types
   // ***************************************************************
   typedef enum logic [1:0] {
      K_WRITE = 2'h0,
      K_ERASE = 2'h1,
      K_FILL  = 2'h2
   } seep_kind_t;

   typedef enum logic [2:0] {
      S_HOLD = 3'h0,
      S_IDLE = 3'h1,
      S_OP   = 3'h3,
      S_ADDR = 3'h2,
      S_DATA = 3'h6,
      S_PUSH = 3'h7,
      S_READ = 3'h5,
      S_DONE = 3'h4
   } seep_state_t;
endpackage

/* src/seep_fifo.sv */
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes both sides run on the one core clock.
 */
`timescale 1ns/100ps
module seep_fifo #(
   parameter int W     = 26,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic         clk_sys_i,
   input  wire logic         rst_i,
   // fill side
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   // drain side
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem_q [DEPTH];
   logic [AW:0]  wp_q, wp_d;
   logic [AW:0]  rp_q, rp_d;
   logic         push, pop;

   // extra pointer bit tells full from empty
   assign out_valid_o = (wp_q != rp_q);
   assign in_ready_o  = (wp_q[AW-1:0] != rp_q[AW-1:0]) || (wp_q[AW] == rp_q[AW]);
   assign out_data_o  = mem_q[rp_q[AW-1:0]];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   // pointer next values
   always_comb begin
      wp_d = push ? wp_q + 1'b1 : wp_q;
      rp_d = pop ? rp_q + 1'b1 : rp_q;
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
      end
   end

   // storage needs no reset
   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem_q[wp_q[AW-1:0]] <= in_data_i;
      end
   end
endmodule // seep_fifo

/* src/seep_core.sv */
/*
 * Serial eeprom slave behind its pins: select, serial clock, serial
 * input, tri-state serial output, ready/busy and width strap.
 * Assumes all pins are asynchronous to clk_sys_i and the serial clock
 * stays well below a tenth of the core clock rate.
 */
// Summary of operation
// - select high selects; select low deselects into standby.
// - a started programming cycle finishes even if select falls.
// - select low holds the sequencer in reset outside S_PUSH, dropping partial instructions.
// - all bits sampled and read bits shifted on rising serial clock edges.
// - serial clock may pause at any level; progress is kept.
// - clock ignored when deselected or while waiting for a start bit.
// - self-timed cycles need no serial clock edges.
// - after the last bit, inputs ignored until reselect after deselect time with ready/busy high.
// - serial output undriven except while shifting read data.
// - a read begins with a leading zero bit.
// - width select high gives 64 x 16, low gives 128 x 8.
// - ready/busy low during program, erase all and fill all.
// - word program within 2 ms, 1 ms in byte mode; erase and fill within 15 ms.
// - start bit is first rising edge with select and input high.
// - write disabled after reset until the enable instruction.
// - read data go out most significant bit first.
// - erase all sets every array bit to one.
`timescale 1ns/100ps
module seep_core #(
   parameter int WR8_TICKS  = seep_pkg::T_WR8_MS * seep_pkg::TICKS_PER_MS,
   parameter int WR16_TICKS = seep_pkg::T_WR16_MS * seep_pkg::TICKS_PER_MS,
   parameter int ALL_TICKS  = seep_pkg::T_ALL_MS * seep_pkg::TICKS_PER_MS,
   parameter int TICK_DIV   = seep_pkg::TICK_CYC
) (
   // clock and reset
   input  wire logic clk_sys_i,
   input  wire logic rst_i,
   // serial pins
   input  wire logic select_i,
   input  wire logic sclk_i,
   input  wire logic serial_in_i,
   output logic      serial_out_o,
   output logic      serial_out_oe_n_o,
   // status and strap
   input  wire logic width_select_i,
   output logic      ready_busy_pin_o
);
   // ***************************************************************
   // pin synchronisers
   // ***************************************************************
   logic [3:0] sy1_q, sy2_q;
   logic       clk_prev_q;
   logic       cs, din, width_select, rise;

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         sy1_q      <= 4'h0;
         sy2_q      <= 4'h0;
         clk_prev_q <= 1'b0;
      end else begin
         sy1_q      <= {select_i, sclk_i, serial_in_i, width_select_i};
         sy2_q      <= sy1_q;
         clk_prev_q <= sy2_q[2];
      end
   end

   assign cs   = sy2_q[3];
   assign din  = sy2_q[1];
   assign width_select  = sy2_q[0];
   assign rise = sy2_q[2] && !clk_prev_q;

   // ***************************************************************
   // timer tick and deselect interval
   // ***************************************************************
   logic [7:0] div_q, div_d;
   logic [3:0] dsl_q, dsl_d;
   logic       tick, dsl_ok, start;

   assign tick   = (div_q == 8'(TICK_DIV - 1));
   assign dsl_ok = (dsl_q == 4'(seep_pkg::MIN_DESEL_CYC));

   // deselect count restarts at each start, saturates while low
   always_comb begin
      div_d = tick ? 8'h00 : div_q + 8'h01;
      dsl_d = dsl_q;
      if (start) begin
         dsl_d = 4'h0;
      end else if (!cs && !dsl_ok) begin
         dsl_d = dsl_q + 4'h1;
      end else if (cs && !dsl_ok) begin
         dsl_d = 4'h0;                                       // too short a low spell
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         div_q <= 8'h00;
         dsl_q <= 4'(seep_pkg::MIN_DESEL_CYC);
      end else begin
         div_q <= div_d;
         dsl_q <= dsl_d;
      end
   end

   // ***************************************************************
   // array and programming engine
   // ***************************************************************
   logic [15:0]                    mem_q [seep_pkg::WORDS];
   logic [seep_pkg::ENT_W-1:0]     f_in, ent;
   logic                           f_in_vld, f_in_rdy, f_out_vld, pop;
   logic                           busy_q, busy_d, commit;
   logic [seep_pkg::TMR_W-1:0]     tmr_q, tmr_d, dur;
   logic [1:0]                     ent_kind;
   logic [6:0]                     ent_adr;
   logic [15:0]                    ent_dat;
   logic                           ent_wide;

   seep_fifo #(
      .W     (seep_pkg::ENT_W),
      .DEPTH (4)
   ) u_fifo (
      .clk_sys_i   (clk_sys_i),
      .rst_i       (rst_i),
      .in_valid_i  (f_in_vld),
      .in_ready_o  (f_in_rdy),
      .in_data_i   (f_in),
      .out_valid_o (f_out_vld),
      .out_ready_i (pop),
      .out_data_o  (ent)
   );

   assign {ent_kind, ent_adr, ent_dat, ent_wide} = ent;
   assign pop    = f_out_vld && !busy_q;
   assign commit = busy_q && tick && (tmr_q == 14'h0001);

   // duration of the entry at the head of the queue
   always_comb begin
      if (ent_kind != seep_pkg::K_WRITE) begin
         dur = 14'(ALL_TICKS);
      end else if (ent_wide) begin
         dur = 14'(WR16_TICKS);
      end else begin
         dur = 14'(WR8_TICKS);
      end
   end

   // countdown in timer ticks of TICK_DIV core clocks, no serial clock involved
   always_comb begin
      busy_d = busy_q;
      tmr_d  = tmr_q;
      if (pop) begin
         busy_d = 1'b1;
         tmr_d  = dur;
      end else if (busy_q && tick) begin
         tmr_d = tmr_q - 14'h0001;
         if (tmr_q == 14'h0001) begin
            busy_d = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         busy_q <= 1'b0;
         tmr_q  <= '0;
      end else begin
         busy_q <= busy_d;
         tmr_q  <= tmr_d;
      end
   end

   // head entry leaves the fifo when the cycle starts, so commit
   // needs a copy; the array itself is kept over reset
   logic [seep_pkg::ENT_W-1:0] cur_q;
   logic [1:0]                 c_kind;
   logic [6:0]                 c_adr;
   logic [15:0]                c_dat;
   logic                       c_wide;

   assign {c_kind, c_adr, c_dat, c_wide} = cur_q;

   always_ff @(posedge clk_sys_i) begin
      if (pop) begin
         cur_q <= ent;
      end
      if (commit) begin
         unique case (c_kind)
            seep_pkg::K_WRITE: begin
               if (c_wide) begin
                  mem_q[c_adr[5:0]] <= c_dat;
               end else if (c_adr[0]) begin
                  mem_q[c_adr[6:1]][15:8] <= c_dat[7:0];
               end else begin
                  mem_q[c_adr[6:1]][7:0] <= c_dat[7:0];
               end
            end
            seep_pkg::K_ERASE: begin
               for (int i = 0; i < seep_pkg::WORDS; i++) begin
                  mem_q[i] <= seep_pkg::ERASED;
               end
            end
            seep_pkg::K_FILL: begin
               for (int i = 0; i < seep_pkg::WORDS; i++) begin
                  mem_q[i] <= c_wide ? c_dat : {c_dat[7:0], c_dat[7:0]};
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ***************************************************************
   // instruction sequencer
   // ***************************************************************
   seep_pkg::seep_state_t st_q, st_d;
   logic [4:0]  cnt_q, cnt_d;
   logic [3:0]  op_q, op_d;
   logic [6:0]  adr_q, adr_d, adr_n;
   logic [15:0] sh_q, sh_d, rword;
   logic        do_q, do_d, oen_q, oen_d, wen_q, wen_d, wide_q, wide_d;
   logic        rdy;
   logic [4:0]  alen, dlen;

   // queued or running work keeps the pin low
   assign rdy      = !(busy_q || f_out_vld || st_q == seep_pkg::S_PUSH);
   assign alen     = wide_q ? 5'(seep_pkg::ADDR_W16) : 5'(seep_pkg::ADDR_W8);
   assign dlen     = wide_q ? 5'(seep_pkg::DATA_W16) : 5'(seep_pkg::DATA_W8);
   assign adr_n    = {adr_q[5:0], din};
   assign start    = (st_q == seep_pkg::S_IDLE) && cs && rise && din;
   assign f_in_vld = (st_q == seep_pkg::S_PUSH);
   assign f_in     = {(op_q[2] ? seep_pkg::K_WRITE :
                       (op_q[1:0] == seep_pkg::OP_ERA ? seep_pkg::K_ERASE : seep_pkg::K_FILL)),
                      adr_q, sh_q, wide_q};

   // read word, byte mode takes a half selected by address bit zero
   always_comb begin
      if (wide_q) begin
         rword = mem_q[adr_n[5:0]];
      end else begin
         rword = {8'h00, adr_n[0] ? mem_q[adr_n[6:1]][15:8] : mem_q[adr_n[6:1]][7:0]};
      end
   end

   always_comb begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      op_d   = op_q;
      adr_d  = adr_q;
      sh_d   = sh_q;
      do_d   = do_q;
      oen_d  = oen_q;
      wen_d  = wen_q;
      wide_d = wide_q;
      // a taken instruction is never lost to a falling select
      if (!cs && st_q != seep_pkg::S_PUSH) begin
         st_d  = seep_pkg::S_HOLD;
         oen_d = 1'b1;
         cnt_d = 5'h00;
      end else begin
         unique case (st_q)
            seep_pkg::S_HOLD: begin
               if (dsl_ok && rdy) begin
                  st_d = seep_pkg::S_IDLE;
               end
            end
            seep_pkg::S_IDLE: begin
               if (start) begin
                  st_d   = seep_pkg::S_OP;
                  cnt_d  = 5'h00;
                  wide_d = width_select;
               end
            end
            seep_pkg::S_OP: begin
               if (rise) begin
                  op_d  = {op_q[2:0], din};
                  cnt_d = cnt_q + 5'h01;
                  if (cnt_q == 5'(seep_pkg::OP_W - 1)) begin
                     st_d  = seep_pkg::S_ADDR;
                     cnt_d = 5'h00;
                  end
               end
            end
            seep_pkg::S_ADDR: begin
               if (rise) begin
                  adr_d = adr_n;
                  cnt_d = cnt_q + 5'h01;
                  if (cnt_q == alen - 5'h01) begin
                     cnt_d = 5'h00;
                     st_d  = seep_pkg::S_DONE;
                     if (op_q[3:2] == 2'b10) begin
                        st_d  = seep_pkg::S_READ;
                        sh_d  = rword;
                        do_d  = 1'b0;
                        oen_d = 1'b0;
                     end else if (op_q[2]) begin
                        st_d = seep_pkg::S_DATA;             // data clocked in even if locked
                     end else if (op_q[1:0] == seep_pkg::OP_EN) begin
                        wen_d = 1'b1;
                     end else if (op_q[1:0] == seep_pkg::OP_DIS) begin
                        wen_d = 1'b0;
                     end else if (op_q[1:0] == seep_pkg::OP_ERA) begin
                        if (wen_q) begin
                           st_d = seep_pkg::S_PUSH;
                        end
                     end else begin
                        st_d = seep_pkg::S_DATA;
                     end
                  end
               end
            end
            seep_pkg::S_DATA: begin
               if (rise) begin
                  sh_d  = {sh_q[14:0], din};
                  cnt_d = cnt_q + 5'h01;
                  if (cnt_q == dlen - 5'h01) begin
                     st_d = wen_q ? seep_pkg::S_PUSH : seep_pkg::S_DONE;
                  end
               end
            end
            seep_pkg::S_PUSH: begin
               if (f_in_rdy) begin
                  st_d = seep_pkg::S_DONE;
               end
            end
            seep_pkg::S_READ: begin
               if (rise) begin
                  if (cnt_q == dlen) begin
                     oen_d = 1'b1;
                     st_d  = seep_pkg::S_DONE;
                  end else begin
                     do_d  = wide_q ? sh_q[15] : sh_q[7];
                     sh_d  = {sh_q[14:0], 1'b0};
                     cnt_d = cnt_q + 5'h01;
                  end
               end
            end
            seep_pkg::S_DONE: begin
               st_d = seep_pkg::S_DONE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         st_q   <= seep_pkg::S_HOLD;
         cnt_q  <= 5'h00;
         op_q   <= 4'h0;
         adr_q  <= 7'h00;
         sh_q   <= 16'h0000;
         do_q   <= 1'b0;
         oen_q  <= 1'b1;
         wen_q  <= 1'b0;
         wide_q <= 1'b1;
      end else begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         op_q   <= op_d;
         adr_q  <= adr_d;
         sh_q   <= sh_d;
         do_q   <= do_d;
         oen_q  <= oen_d;
         wen_q  <= wen_d;
         wide_q <= wide_d;
      end
   end

   assign serial_out_o      = do_q;
   assign serial_out_oe_n_o = oen_q;
   assign ready_busy_pin_o  = rdy;

   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   a_desel_holds: assert property (!cs && st_q != seep_pkg::S_PUSH |=> st_q == seep_pkg::S_HOLD)
      else $error("sequencer not held while deselected");
   a_drive_only_read: assert property (!oen_q |-> st_q == seep_pkg::S_READ)
      else $error("output driven outside a read");
   a_dummy_zero: assert property (st_q != seep_pkg::S_READ ##1 st_q == seep_pkg::S_READ
                                  |-> !do_q && !oen_q)
      else $error("read did not start with a zero");
   a_busy_low: assert property (busy_q |-> !ready_busy_pin_o)
      else $error("ready shown while programming");
   a_start_cond: assert property (st_q == seep_pkg::S_IDLE ##1 st_q == seep_pkg::S_OP
                                  |-> $past(rise) && $past(din))
      else $error("sequence began without a start bit");
   a_locked_no_push: assert property (f_in_vld |-> wen_q)
      else $error("programming queued while disabled");
   a_pause_keeps: assert property (cs && !rise && st_q inside {seep_pkg::S_OP, seep_pkg::S_ADDR,
                                   seep_pkg::S_DATA, seep_pkg::S_READ} |=> $stable(cnt_q) && $stable(st_q))
      else $error("progress changed without a clock edge");
   a_idle_waits: assert property (st_q == seep_pkg::S_IDLE && cs && !din |=> st_q == seep_pkg::S_IDLE)
      else $error("left idle without a start bit");
   a_done_ignores: assert property (st_q == seep_pkg::S_DONE && cs |=> st_q == seep_pkg::S_DONE)
      else $error("finished instruction did not wait for deselect");
   a_cycle_survives: assert property (busy_q && !cs && tmr_q > 14'h0001 |=> busy_q)
      else $error("programming cut short by deselect");
   a_timer_load: assert property (pop |=> tmr_q == $past(dur) && busy_q)
      else $error("cycle timer loaded wrongly");
   a_msb_first: assert property (st_q == seep_pkg::S_READ && rise && cnt_q < dlen && cs
                                 |=> do_q == (wide_q ? $past(sh_q[15]) : $past(sh_q[7])))
      else $error("read bit out of order");

   c_read: cover property (st_q == seep_pkg::S_READ ##1 st_q == seep_pkg::S_DONE);
   c_write_push: cover property (f_in_vld && f_in_rdy && op_q[2]);
   c_erase_done: cover property (commit && c_kind == seep_pkg::K_ERASE);
   c_desel_busy: cover property (busy_q && !cs);
endmodule // seep_core

/* tb/seep_host.sv */
/*
 * Host model: bus master on the serial pins (select, serial clock, serial in).
 * Assumes the 100 MHz core clock; serial clock period 160 ns plus twice the hold, still outside frames.
 */
`timescale 1ns/100ps
module seep_host (
   // core clock
   input  wire logic clk_sys_i,
   // serial pins
   output logic      select_o,
   output logic      sclk_o,
   output logic      serial_in_o,
   input  wire logic serial_out_i,
   input  wire logic serial_out_oe_n_i
);
   // the output wire has no pull, so undriven shows as z
   wire line_w = serial_out_oe_n_i ? 1'bz : serial_out_i;

   // ***************************************************************
   // idle pins
   // ***************************************************************
   initial begin
      select_o = 1'b0;
      sclk_o = 1'b0;
      serial_in_o = 1'b0;
   end

   // ***************************************************************
   // one frame, n edges, msb of bits first; hold pauses the clock
   // ***************************************************************
   task automatic frame(input logic [31:0] bits, input int n, input int hold, output logic [31:0] rx);
      rx = '0;
      select_o <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      for (int i = n - 1; i >= 0; i--) begin
         serial_in_o <= bits[i];              // stable 40 ns before the rise
         repeat (4 + hold) @(posedge clk_sys_i);
         sclk_o <= 1'b1;
         repeat (8 + hold) @(posedge clk_sys_i); // pause at both levels
         rx = {rx[30:0], line_w};
         sclk_o <= 1'b0;
         repeat (4) @(posedge clk_sys_i);
      end
      select_o <= 1'b0;
      serial_in_o <= ~serial_in_o;            // released line does not keep its value
      repeat (12) @(posedge clk_sys_i);       // beyond min_deselect_time
   endtask
endmodule // seep_host

/* tb/tb.sv */
/*
 * Bench for the serial eeprom slave with a word model of the array,
 * plus a queue of pending writes that pass the design's own programming queue.
 * Assumes shortened cycle parameters: ticks of 20 core clocks.
 */
`timescale 1ns/100ps
module tb;
   // ***************************************************************
   // signals
   // ***************************************************************
   localparam int DIV = 20;
   logic        clk_sys_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        width_select_i = 1'b1;
   logic        select_w, sclk_w, sin_w, sout_w, oe_n_w, rdy_w;
   logic [7:0]  b;
   logic [15:0] mem [64];
   logic [31:0] rx;
   logic [15:0] d;
   logic [6:0]  a;
   logic [15:0] pend [$];
   int          n_mismatch = 0;
   int          cmp_count = 0;
   int          cyc = 0;

   always #5 clk_sys_i = ~clk_sys_i;

   seep_core #(.WR8_TICKS(3), .WR16_TICKS(6), .ALL_TICKS(8), .TICK_DIV(DIV)) u_dut (.clk_sys_i(clk_sys_i),
      .rst_i(rst_i), .select_i(select_w), .sclk_i(sclk_w), .serial_in_i(sin_w), .serial_out_o(sout_w),
      .serial_out_oe_n_o(oe_n_w), .width_select_i(width_select_i), .ready_busy_pin_o(rdy_w));
   seep_host u_host (.clk_sys_i(clk_sys_i), .select_o(select_w), .sclk_o(sclk_w), .serial_in_o(sin_w),
      .serial_out_i(sout_w), .serial_out_oe_n_i(oe_n_w));

   // ***************************************************************
   // checks and transfers
   // ***************************************************************
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   // frame, then busy expected only when ticks is nonzero; wait bounded by the cycle time
   task automatic run(input logic [31:0] bits, input int n, input int ticks);
      int k;
      u_host.frame(bits, n, $urandom_range(0, 6), rx);
      chk({31'h0, rdy_w}, {31'h0, ticks == 0});  // busy after deselect, or refused
      k = 0;
      while (rdy_w !== 1'b1 && k < ticks * DIV - 10) begin
         @(posedge clk_sys_i);
         k++;
      end
      chk({31'h0, rdy_w}, 32'h1);
      chk({31'h0, oe_n_w}, 32'h1);
   endtask

   task automatic rd_word(input logic [5:0] adr);
      run({5'h0, 1'b1, 4'h8, adr, 16'h0}, 29, 0);  // idle edges first
      chk({15'h0, rx[16:0]}, {16'h0, mem[adr]});
   endtask

   task automatic rd_byte(input logic [6:0] adr);
      run({12'h0, 1'b1, 4'h8, adr, 8'h0}, 20, 0);
      chk({23'h0, rx[8:0]}, {24'h0, adr[0] ? mem[adr[6:1]][15:8] : mem[adr[6:1]][7:0]});
   endtask

   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_mismatch++;
         complete_run();
      end
   end

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      void'($urandom(65895));
      repeat (3) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      run({21'h0, 1'b1, 4'h2, 6'h0}, 11, 0);     // erase while disabled
      run({21'h0, 1'b1, 4'h3, 6'h0}, 11, 0);
      run({21'h0, 1'b1, 4'h2, 6'h0}, 11, 8);
      foreach (mem[i]) mem[i] = 16'hFFFF;
      a = 7'($urandom_range(0, 63));
      rd_word(a[5:0]);
      d = 16'($urandom);
      run({3'h0, 1'b1, 4'h4, a[5:0], d, 2'h3}, 29, 6); // extra edges ignored
      mem[a[5:0]] = d;
      rd_word(a[5:0]);
      run({21'h0, 1'b1, 4'h0, 6'h0}, 11, 0);
      run({5'h0, 1'b1, 4'h4, a[5:0], ~d}, 27, 0);
      run({29'h0, 3'h5}, 3, 0);                  // aborted instruction
      rd_word(a[5:0]);
      $display("test word done");
      width_select_i <= 1'b0;                    // strap driven firmly, never floating
      run({20'h0, 1'b1, 4'h3, 7'h0}, 12, 0);
      a = 7'($urandom);
      b = 8'($urandom);
      run({12'h0, 1'b1, 4'h4, a, b}, 20, 3);
      if (a[0]) mem[a[6:1]][15:8] = b; else mem[a[6:1]][7:0] = b;
      rd_byte(a);
      rd_byte(a ^ 7'h01);
      run({12'h0, 1'b1, 4'h1, 7'h0, ~b}, 20, 8);
      foreach (mem[i]) mem[i] = {~b, ~b};
      rd_byte(7'($urandom));
      width_select_i <= 1'b1;
      rd_word(6'($urandom));
      $display("test byte done");
      // a word write passes the internal programming queue; the model keeps it pending till done
      d = 16'($urandom);
      pend.push_back(d);
      run({5'h0, 1'b1, 4'h4, a[5:0], d}, 27, 6); // pin low until the queued entry lands
      mem[a[5:0]] = pend.pop_front();
      rd_word(a[5:0]);
      chk(pend.size(), 0);
      $display("test fifo done");
      complete_run();
   end
endmodule // tb
